// ===== hdl/dpm_pkg.sv
// Purpose: Shared constants and types of the codepoint priority map bank.
// Assumes: One switch clock, asynchronous active-low reset.
// Notes: Byte offsets are the register port addresses.
package dpm_pkg;

    localparam int unsigned DPM_DATA_W = 8;
    localparam int unsigned DPM_ADDR_W = 8;
    localparam int unsigned DPM_PRIO_W = 2;
    localparam int unsigned DPM_CODE_W = 6;
    localparam int unsigned DPM_NUM_REGS = 8;
    localparam int unsigned DPM_IDX_W = 3;
    localparam int unsigned DPM_NUM_CODES = 32;
    localparam int unsigned DPM_FIELD_IDX_W = 5;
    localparam int unsigned DPM_TABLE_W = DPM_NUM_REGS * DPM_DATA_W;

    // Register offsets
    localparam logic [7:0] DPM_OFS_PRIO_5 = 8'h65;
    localparam logic [7:0] DPM_OFS_PRIO_6 = 8'h66;
    localparam logic [7:0] DPM_OFS_PRIO_7 = 8'h67;
    localparam logic [7:0] DPM_OFS_PRIO_8 = 8'h68;
    localparam logic [7:0] DPM_OFS_PRIO_9 = 8'h69;
    localparam logic [7:0] DPM_OFS_PRIO_10 = 8'h6A;
    localparam logic [7:0] DPM_OFS_PRIO_11 = 8'h6B;
    localparam logic [7:0] DPM_OFS_PRIO_12 = 8'h6C;
    localparam logic [7:0] DPM_OFS_FIRST = DPM_OFS_PRIO_5;
    localparam logic [7:0] DPM_OFS_LAST = DPM_OFS_PRIO_12;

    // Codepoint range served by this bank
    localparam logic [5:0] DPM_CODE_FIRST = 6'h14;
    localparam logic [5:0] DPM_CODE_LAST = 6'h33;
    localparam int unsigned DPM_TOS_CODE_LSB = 2;

    // Reset values
    localparam logic [7:0] DPM_RST_PRIO = 8'h00;
    localparam logic [1:0] DPM_PRIO_NONE = 2'h0;

    typedef logic [DPM_TABLE_W-1:0] dpm_table_t;

    typedef struct packed {
        logic valid;
        logic [DPM_DATA_W-1:0] tos;
    } dpm_frame_s;

    typedef struct packed {
        logic valid;
        logic hit;
        logic [DPM_PRIO_W-1:0] prio;
    } dpm_prio_s;

    typedef struct packed {
        logic wr;
        logic [DPM_IDX_W-1:0] idx;
        logic [DPM_DATA_W-1:0] data;
    } dpm_wr_s;

    typedef struct packed {
        logic [DPM_NUM_REGS-1:0][DPM_DATA_W-1:0] regs;
    } dpm_bank_s;

    typedef struct packed {
        logic [DPM_DATA_W-1:0] rdata;
        logic ack;
        logic miss;
    } dpm_bus_s;

endpackage : dpm_pkg

// ===== hdl/dpm_reg_bank.sv
// Purpose: Storage of the eight priority map bytes.
// Assumes: Write strobe already decoded to a byte index.
// Notes: Byte 0 holds codes 0x14 to 0x17, lowest code in bits 1-0.
`timescale 1ns/1ps
module dpm_reg_bank (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire dpm_pkg::dpm_wr_s wr_in,
    output dpm_pkg::dpm_table_t table_out
);

    dpm_pkg::dpm_bank_s state_q;
    dpm_pkg::dpm_bank_s state_d;

    always_comb begin
        state_d = state_q;
        if (wr_in.wr) begin
            state_d.regs[wr_in.idx] = wr_in.data;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= {dpm_pkg::DPM_NUM_REGS{dpm_pkg::DPM_RST_PRIO}};
        end else begin
            state_q <= state_d;
        end
    end

    assign table_out = state_q.regs;

endmodule : dpm_reg_bank

// ===== hdl/dpm_lookup.sv
// Purpose: Maps a frame's codepoint to its two-bit priority.
// Assumes: Table and frame are stable in the sampling cycle.
// Notes: Result registered, one cycle after the frame strobe.
`timescale 1ns/1ps
module dpm_lookup (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire dpm_pkg::dpm_table_t table_in,
    input wire dpm_pkg::dpm_frame_s frame_in,
    input wire logic enable_in,
    output dpm_pkg::dpm_prio_s result_out
);

    logic [dpm_pkg::DPM_PRIO_W-1:0] field_w [dpm_pkg::DPM_NUM_CODES];
    dpm_pkg::dpm_prio_s state_q;
    dpm_pkg::dpm_prio_s state_d;

    // One field per codepoint, in code order
    for (genvar g = 0; g < dpm_pkg::DPM_NUM_CODES; g++) begin : g_field
        assign field_w[g] = table_in[g * dpm_pkg::DPM_PRIO_W +: dpm_pkg::DPM_PRIO_W];
    end

    always_comb begin
        logic [dpm_pkg::DPM_CODE_W-1:0] code;
        logic [dpm_pkg::DPM_FIELD_IDX_W-1:0] fidx;
        code = frame_in.tos[dpm_pkg::DPM_TOS_CODE_LSB +: dpm_pkg::DPM_CODE_W];
        fidx = dpm_pkg::DPM_FIELD_IDX_W'(code - dpm_pkg::DPM_CODE_FIRST);
        state_d.valid = frame_in.valid & enable_in;
        state_d.hit = (code >= dpm_pkg::DPM_CODE_FIRST) && (code <= dpm_pkg::DPM_CODE_LAST);
        state_d.prio = state_d.hit ? field_w[fidx] : dpm_pkg::DPM_PRIO_NONE;
        if (!state_d.valid) begin
            state_d.hit = 1'b0;
            state_d.prio = dpm_pkg::DPM_PRIO_NONE;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign result_out = state_q;

endmodule : dpm_lookup

// ===== hdl/dpm_priority_map_regs.sv
// Purpose: Codepoint priority map registers 0x65 to 0x6C and their lookup.
// Assumes: Register port and frame inputs synchronous to clk_in.
// Notes: Reads answer one cycle after the strobe; lookups likewise.
// Contract
// - Frame code is type-of-service byte bits 7-2; frame gets that field's priority.
// - Codes 0x14, 0x15, 0x16 use bits 1-0, 3-2, 5-4 of byte 0x65.
// - Byte 0x66 serves codes 0x18 to 0x1B, lowest code in bits 1-0.
// - Byte 0x67 serves codes 0x1C to 0x1F, ascending bit pairs.
// - Byte 0x68 serves codes 0x20 to 0x23, 0x23 in bits 7-6.
// - Byte 0x69 serves codes 0x24 to 0x27, 0x27 in bits 7-6.
// - Byte 0x6A serves codes 0x28 to 0x2B, 0x2B in bits 7-6.
// - Byte 0x6B serves codes 0x2C to 0x2F, 0x2F in bits 7-6.
// - Byte 0x6C bits 3-2, 5-4, 7-6 serve codes 0x31, 0x32, 0x33.
// - All fields read and write; each resets to priority 00.
// - Byte 0x65 holds codes 0x14 to 0x17; 0x17 in bits 7-6.
// - Code 0x30 uses bits 1-0 of byte 0x6C.
`timescale 1ns/1ps
module dpm_priority_map_regs (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [dpm_pkg::DPM_ADDR_W-1:0] reg_addr_in,
    input wire logic [dpm_pkg::DPM_DATA_W-1:0] reg_wdata_in,
    output logic [dpm_pkg::DPM_DATA_W-1:0] reg_rdata_out,
    output logic reg_ack_out,
    output logic reg_miss_out,
    input wire logic frame_valid_in,
    input wire logic [dpm_pkg::DPM_DATA_W-1:0] frame_tos_in,
    input wire logic class_en_in,
    output logic prio_valid_out,
    output logic prio_hit_out,
    output logic [dpm_pkg::DPM_PRIO_W-1:0] prio_out
);

    dpm_pkg::dpm_bus_s state_q;
    dpm_pkg::dpm_bus_s state_d;
    dpm_pkg::dpm_table_t table_w;
    dpm_pkg::dpm_wr_s wr_w;
    dpm_pkg::dpm_frame_s frame_w;
    dpm_pkg::dpm_prio_s result_w;
    logic in_range_w;
    logic [dpm_pkg::DPM_IDX_W-1:0] idx_w;
    logic [dpm_pkg::DPM_DATA_W-1:0] rd_byte_w;

    // Address decode of the eight bytes
    assign in_range_w = (reg_addr_in >= dpm_pkg::DPM_OFS_FIRST) && (reg_addr_in <= dpm_pkg::DPM_OFS_LAST);
    assign idx_w = dpm_pkg::DPM_IDX_W'(reg_addr_in - dpm_pkg::DPM_OFS_FIRST);
    assign rd_byte_w = table_w[{idx_w, 3'h0} +: dpm_pkg::DPM_DATA_W];

    always_comb begin
        wr_w.wr = reg_wr_in & in_range_w;
        wr_w.idx = idx_w;
        wr_w.data = reg_wdata_in;
    end

    always_comb begin
        state_d.ack = (reg_rd_in | reg_wr_in) & in_range_w;
        state_d.miss = (reg_rd_in | reg_wr_in) & ~in_range_w;
        // Unmapped reads return zero; read beside a write sees old byte
        state_d.rdata = (reg_rd_in & in_range_w) ? rd_byte_w : dpm_pkg::DPM_RST_PRIO;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign reg_rdata_out = state_q.rdata;
    assign reg_ack_out = state_q.ack;
    assign reg_miss_out = state_q.miss;

    dpm_reg_bank u_bank (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .wr_in(wr_w),
        .table_out(table_w)
    );

    assign frame_w.valid = frame_valid_in;
    assign frame_w.tos = frame_tos_in;

    dpm_lookup u_lookup (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .table_in(table_w),
        .frame_in(frame_w),
        .enable_in(class_en_in),
        .result_out(result_w)
    );

    assign prio_valid_out = result_w.valid;
    assign prio_hit_out = result_w.hit;
    assign prio_out = result_w.prio;

    // Checks

    default clocking cb @(posedge clk_in);
    endclocking

    default disable iff (!arst_n_in);

    logic [dpm_pkg::DPM_CODE_W-1:0] code_w;
    logic lookup_w;
    assign code_w = frame_tos_in[7:2];
    assign lookup_w = frame_valid_in && class_en_in;

    property p_map(logic [5:0] c, logic [1:0] fld);
        lookup_w && code_w == c
        |=> prio_valid_out && prio_hit_out && prio_out == $past(fld);
    endproperty

    a_code_14_map:
        assert property (p_map(6'h14, table_w[1:0]))
        else $error("code 0x14 priority wrong");

    a_code_15_map:
        assert property (p_map(6'h15, table_w[3:2]))
        else $error("code 0x15 priority wrong");

    a_code_16_map:
        assert property (p_map(6'h16, table_w[5:4]))
        else $error("code 0x16 priority wrong");

    a_code_17_map:
        assert property (p_map(6'h17, table_w[7:6]))
        else $error("code 0x17 priority wrong");

    a_code_18_map:
        assert property (p_map(6'h18, table_w[9:8]))
        else $error("code 0x18 priority wrong");

    a_code_1b_map:
        assert property (p_map(6'h1B, table_w[15:14]))
        else $error("code 0x1B priority wrong");

    a_code_1c_map:
        assert property (p_map(6'h1C, table_w[17:16]))
        else $error("code 0x1C priority wrong");

    a_code_1f_map:
        assert property (p_map(6'h1F, table_w[23:22]))
        else $error("code 0x1F priority wrong");

    a_code_20_map:
        assert property (p_map(6'h20, table_w[25:24]))
        else $error("code 0x20 priority wrong");

    a_code_23_map:
        assert property (p_map(6'h23, table_w[31:30]))
        else $error("code 0x23 priority wrong");

    a_code_24_map:
        assert property (p_map(6'h24, table_w[33:32]))
        else $error("code 0x24 priority wrong");

    a_code_27_map:
        assert property (p_map(6'h27, table_w[39:38]))
        else $error("code 0x27 priority wrong");

    a_code_28_map:
        assert property (p_map(6'h28, table_w[41:40]))
        else $error("code 0x28 priority wrong");

    a_code_2b_map:
        assert property (p_map(6'h2B, table_w[47:46]))
        else $error("code 0x2B priority wrong");

    a_code_2c_map:
        assert property (p_map(6'h2C, table_w[49:48]))
        else $error("code 0x2C priority wrong");

    a_code_2f_map:
        assert property (p_map(6'h2F, table_w[55:54]))
        else $error("code 0x2F priority wrong");

    a_code_30_map:
        assert property (p_map(6'h30, table_w[57:56]))
        else $error("code 0x30 priority wrong");

    a_code_31_map:
        assert property (p_map(6'h31, table_w[59:58]))
        else $error("code 0x31 priority wrong");

    a_code_32_map:
        assert property (p_map(6'h32, table_w[61:60]))
        else $error("code 0x32 priority wrong");

    a_code_33_map:
        assert property (p_map(6'h33, table_w[63:62]))
        else $error("code 0x33 priority wrong");

    a_code_19_map:
        assert property (p_map(6'h19, table_w[11:10]))
        else $error("code 0x19 priority wrong");

    a_code_1a_map:
        assert property (p_map(6'h1A, table_w[13:12]))
        else $error("code 0x1A priority wrong");

    a_code_1d_map:
        assert property (p_map(6'h1D, table_w[19:18]))
        else $error("code 0x1D priority wrong");

    a_code_1e_map:
        assert property (p_map(6'h1E, table_w[21:20]))
        else $error("code 0x1E priority wrong");

    a_code_21_map:
        assert property (p_map(6'h21, table_w[27:26]))
        else $error("code 0x21 priority wrong");

    a_code_22_map:
        assert property (p_map(6'h22, table_w[29:28]))
        else $error("code 0x22 priority wrong");

    a_code_25_map:
        assert property (p_map(6'h25, table_w[35:34]))
        else $error("code 0x25 priority wrong");

    a_code_26_map:
        assert property (p_map(6'h26, table_w[37:36]))
        else $error("code 0x26 priority wrong");

    a_code_29_map:
        assert property (p_map(6'h29, table_w[43:42]))
        else $error("code 0x29 priority wrong");

    a_code_2a_map:
        assert property (p_map(6'h2A, table_w[45:44]))
        else $error("code 0x2A priority wrong");

    a_code_2d_map:
        assert property (p_map(6'h2D, table_w[51:50]))
        else $error("code 0x2D priority wrong");

    a_code_2e_map:
        assert property (p_map(6'h2E, table_w[53:52]))
        else $error("code 0x2E priority wrong");

    a_code_outside:
        assert property (lookup_w && (code_w < 6'h14 || code_w > 6'h33)
            |=> prio_valid_out && !prio_hit_out && prio_out == 2'h0)
        else $error("code outside bank must miss");

    a_low_bits_ignored:
        assert property (lookup_w ##1 lookup_w && code_w == $past(code_w)
            && !$past(reg_wr_in) && !$past(reg_wr_in, 2)
            |=> prio_out == $past(prio_out) && prio_hit_out == $past(prio_hit_out))
        else $error("priority depends on bits below the code");

    a_class_gate:
        assert property (!(frame_valid_in && class_en_in)
            |=> !prio_valid_out && !prio_hit_out && prio_out == 2'h0)
        else $error("priority offered while classification off");

    a_write_lands:
        assert property (reg_wr_in && in_range_w
            |=> table_w[{$past(idx_w), 3'h0} +: 8] == $past(reg_wdata_in))
        else $error("written byte not stored");

    a_table_holds:
        assert property (!(reg_wr_in && in_range_w) |=> $stable(table_w))
        else $error("table changed without a write");

    a_read_back:
        assert property (reg_rd_in && in_range_w
            |=> reg_ack_out && !reg_miss_out && reg_rdata_out == $past(rd_byte_w))
        else $error("read data does not match stored byte");

    a_write_read:
        assert property (reg_wr_in && in_range_w ##1 reg_rd_in && !reg_wr_in
            && reg_addr_in == $past(reg_addr_in)
            |=> reg_rdata_out == $past(reg_wdata_in, 2))
        else $error("write then read mismatch");

    a_reset_zero:
        assert property ($rose(arst_n_in) |-> table_w == '0 && !prio_valid_out)
        else $error("fields not zero after reset");

    a_unmapped:
        assert property ((reg_rd_in || reg_wr_in) && !in_range_w
            |=> reg_miss_out && !reg_ack_out && reg_rdata_out == 8'h00)
        else $error("unmapped access not refused");

    a_write_ack:
        assert property (reg_wr_in && in_range_w |=> reg_ack_out && !reg_miss_out)
        else $error("mapped write not acknowledged");

    a_bus_quiet:
        assert property (!(reg_rd_in || reg_wr_in) |=> !reg_ack_out && !reg_miss_out && reg_rdata_out == 8'h00)
        else $error("register answer without a strobe");

    a_prio_only_hit:
        assert property (prio_out != 2'h0 |-> prio_valid_out && prio_hit_out)
        else $error("priority shown without a valid hit");

    c_write_lookup:
        cover property (reg_wr_in && in_range_w ##1 lookup_w ##1 prio_hit_out && prio_out == 2'h3);

    c_unmapped:
        cover property (reg_rd_in && !in_range_w ##1 reg_miss_out);

    c_class_off:
        cover property (frame_valid_in && !class_en_in ##1 !prio_valid_out);

    c_back_to_back:
        cover property (lookup_w [*3] ##1 prio_valid_out && prio_hit_out);

endmodule : dpm_priority_map_regs

// ===== tb/testbench.sv
// Purpose: Self-checking bench of the codepoint priority map bank.
// Assumes: Strobes taken at rising edge, answers one cycle later.
// Notes: Inputs driven at falling edge; reference copy of bank in mdl.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module testbench;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic [7:0] reg_rdata_out;
    logic reg_ack_out;
    logic reg_miss_out;
    logic frame_valid_in = 1'b0;
    logic [7:0] frame_tos_in = 8'h00;
    logic class_en_in = 1'b0;
    logic prio_valid_out;
    logic prio_hit_out;
    logic [1:0] prio_out;
    logic [7:0] mdl [8];
    int n_mismatch = 0;
    int comparisons = 0;

    dpm_priority_map_regs u_dpm_priority_map_regs (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .reg_ack_out(reg_ack_out), .reg_miss_out(reg_miss_out), .frame_valid_in(frame_valid_in),
        .frame_tos_in(frame_tos_in), .class_en_in(class_en_in), .prio_valid_out(prio_valid_out),
        .prio_hit_out(prio_hit_out), .prio_out(prio_out)
    );

    always #12.5 clk_in = ~clk_in;

    task automatic tally_and_finish();
        $display("Mismatches %0d of %0d comparisons", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    function automatic logic mapped(input logic [7:0] addr);
        return addr >= 8'h65 && addr <= 8'h6C;
    endfunction : mapped

    // Hit flag and priority of a code, from the reference copy
    function automatic logic [2:0] exp_lookup(input logic [5:0] code);
        logic [5:0] rel;
        rel = code - 6'h14;
        if (code < 6'h14 || code > 6'h33) begin
            return 3'h0;
        end
        return {1'b1, mdl[rel[4:2]][2*rel[1:0] +: 2]};
    endfunction : exp_lookup

    task automatic reg_access(input logic wr, input logic rd, input logic [7:0] addr, input logic [7:0] wdata);
        logic [7:0] exp_rd;
        exp_rd = (rd && mapped(addr)) ? mdl[addr - 8'h65] : 8'h00;
        @(negedge clk_in);
        reg_wr_in = wr;
        reg_rd_in = rd;
        reg_addr_in = addr;
        reg_wdata_in = wdata;
        @(negedge clk_in);
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        if (wr && mapped(addr)) begin
            mdl[addr - 8'h65] = wdata;
        end
        `CHK("ack", mapped(addr), reg_ack_out)
        `CHK("miss", !mapped(addr), reg_miss_out)
        `CHK("rdata", exp_rd, reg_rdata_out)
    endtask : reg_access

    task automatic check_prio(input logic en, input logic [5:0] code);
        logic [2:0] e;
        e = en ? exp_lookup(code) : 3'h0;
        `CHK("prio_valid", en, prio_valid_out)
        `CHK("prio_hit", e[2], prio_hit_out)
        `CHK("prio", e[1:0], prio_out)
    endtask : check_prio

    task automatic send_frame(input logic [7:0] tos, input logic en);
        @(negedge clk_in);
        frame_valid_in = 1'b1;
        frame_tos_in = tos;
        class_en_in = en;
        @(negedge clk_in);
        frame_valid_in = 1'b0;
        check_prio(en, tos[7:2]);
    endtask : send_frame

    task automatic all_regs_and_codes(input int pass);
        logic [7:0] pat;
        for (int i = 0; i < 8; i++) begin
            pat = (pass == 0) ? 8'hE4 : (pass == 1) ? {4{i[1:0]}} : (pass == 2) ? {4{1'b0, i[2]}} : 8'h1B;
            reg_access(1'b1, 1'b0, 8'h65 + 8'(i), pat);
        end
        for (int i = 0; i < 8; i++) begin
            reg_access(1'b0, 1'b1, 8'h65 + 8'(i), 8'h00);
        end
        // Low two type-of-service bits vary and must be ignored
        for (int c = 8'h14; c <= 8'h23; c++) begin
            send_frame({6'(c), 2'(c)}, 1'b1);
        end
        for (int c = 8'h24; c <= 8'h33; c++) begin
            send_frame({6'(c), 2'(c)}, 1'b1);
        end
    endtask : all_regs_and_codes

    initial begin
        for (int i = 0; i < 8; i++) begin
            mdl[i] = 8'h00;
        end
        repeat (5) @(negedge clk_in);
        arst_n_in = 1'b1;
        for (int i = 0; i < 8; i++) begin
            reg_access(1'b0, 1'b1, 8'h65 + 8'(i), 8'h00);
        end
        send_frame(8'h50, 1'b1);
        for (int p = 0; p < 4; p++) begin
            all_regs_and_codes(p);
        end
        // Unmapped neighbours: ignored write, zero read
        reg_access(1'b1, 1'b0, 8'h64, 8'hFF);
        reg_access(1'b1, 1'b0, 8'h6D, 8'hFF);
        reg_access(1'b0, 1'b1, 8'h64, 8'h00);
        reg_access(1'b0, 1'b1, 8'h6D, 8'h00);
        reg_access(1'b1, 1'b0, 8'hFF, 8'hAA);
        reg_access(1'b0, 1'b1, 8'h65, 8'h00);
        reg_access(1'b0, 1'b1, 8'h6C, 8'h00);
        // Read and write in one cycle: old value read, new value kept
        reg_access(1'b1, 1'b1, 8'h6C, 8'hC6);
        reg_access(1'b0, 1'b1, 8'h6C, 8'h00);
        // Codes outside this bank: its two neighbours and codes 0x00 and 0x3F
        send_frame(8'h4F, 1'b1);
        send_frame(8'hD0, 1'b1);
        send_frame(8'h00, 1'b1);
        send_frame(8'hFF, 1'b1);
        // Classification disabled
        send_frame(8'hC0, 1'b0);
        send_frame(8'h5C, 1'b0);
        // Back-to-back frames, first two share a code
        @(negedge clk_in);
        frame_valid_in = 1'b1;
        frame_tos_in = 8'hC4;
        class_en_in = 1'b1;
        @(negedge clk_in);
        frame_tos_in = 8'hC7;
        check_prio(1'b1, 6'h31);
        @(negedge clk_in);
        frame_tos_in = 8'hCC;
        check_prio(1'b1, 6'h31);
        @(negedge clk_in);
        frame_valid_in = 1'b0;
        check_prio(1'b1, 6'h33);
        @(negedge clk_in);
        check_prio(1'b0, 6'h33);
        // Lookup in the cycle of a write sees the old table
        @(negedge clk_in);
        reg_wr_in = 1'b1;
        reg_addr_in = 8'h66;
        reg_wdata_in = 8'h02;
        frame_valid_in = 1'b1;
        frame_tos_in = 8'h60;
        @(negedge clk_in);
        reg_wr_in = 1'b0;
        frame_valid_in = 1'b0;
        check_prio(1'b1, 6'h18);
        mdl[1] = 8'h02;
        send_frame(8'h63, 1'b1);
        // Write then read of one byte in back-to-back cycles
        @(negedge clk_in);
        reg_wr_in = 1'b1;
        reg_addr_in = 8'h69;
        reg_wdata_in = 8'h5A;
        @(negedge clk_in);
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b1;
        mdl[4] = 8'h5A;
        `CHK("ack", 1'b1, reg_ack_out)
        @(negedge clk_in);
        reg_rd_in = 1'b0;
        `CHK("rdata", 8'h5A, reg_rdata_out)
        // Reset in mid-run clears every field
        @(negedge clk_in);
        arst_n_in = 1'b0;
        repeat (2) @(negedge clk_in);
        arst_n_in = 1'b1;
        for (int i = 0; i < 8; i++) begin
            mdl[i] = 8'h00;
            reg_access(1'b0, 1'b1, 8'h65 + 8'(i), 8'h00);
        end
        send_frame(8'hCF, 1'b1);
        tally_and_finish();
    end

    // Run takes about 470 cycles; cut off far beyond that
    initial begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        tally_and_finish();
    end
endmodule : testbench
